// *** design/cmmd_core.sv ***
// CPU core with data space decoder and program memory section guard
// Overview of operation
// - Next instruction is fetched while the current one executes.
// - Thirty-two byte registers, two read in one cycle for one operation.
// - Six registers pair into three 16-bit data pointers; only Z also addresses program space.
// - Status flags describe the result of every arithmetic operation.
// - Program and data spaces are separate linear spaces.
// - All I/O registers lie in the lowest 4KB of data space.
// - Locations 0x00 to 0x3F reachable by direct I/O and data access.
// - Extended I/O 0x0040 to 0x0FFF reachable only by data load/store.
// - Data addresses 0x1000 to 0x1FFF form the EEPROM window.
// - SRAM begins at 0x2000, reachable by every data addressing mode.
// - Instructions are fetched only from program memory, never SRAM.
// - Application and boot parts each have write and read/write locks.
// - Application flash stores take effect only when fetched from boot part.
// - Table subsection has its own write and read/write lock bits.
`timescale 1ns/1ps
module cmmd_core
	import cmmd_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// Program memory fetch port
	output logic [15:0]      prog_addr,
	input  wire logic [15:0] prog_rdata,
	// Data space port
	output logic [15:0]      data_addr,
	output logic [7:0]       data_wdata,
	input  wire logic [7:0]  data_rdata,
	output logic             data_re,
	output logic             data_we,
	output logic             io_sel,
	output logic             eep_sel,
	output logic             sram_sel,
	// Flash self-programming port
	output logic             flash_wr,
	output logic [15:0]      flash_wr_addr,
	output logic [7:0]       flash_wr_data,
	// Section lock bits
	input  wire logic        lock_app_wr,
	input  wire logic        lock_app_rw,
	input  wire logic        lock_tbl_wr,
	input  wire logic        lock_tbl_rw,
	input  wire logic        lock_boot_wr,
	input  wire logic        lock_boot_rw,
	// Status
	output logic [7:0]       status_flags,
	output logic             access_fault
);

	// Decode a data address into one-hot target selects
	function automatic logic [2:0] dec_target(input logic [15:0] a);
		logic [2:0] s;
		s = 3'h0;
		if (a <= IO_LAST)                               s[SEL_IO] = 1'b1;
		else if (a >= EEP_FIRST && a <= EEP_LAST)       s[SEL_EEP] = 1'b1;
		else if (a >= SRAM_FIRST && a <= SRAM_LAST)     s[SEL_SRAM] = 1'b1;
		return s;
	endfunction : dec_target

	// Section of a program word address
	function automatic logic [1:0] sect_of(input logic [15:0] w);
		if (w >= BOOT_FIRST_WORD)
			return SECT_BOOT;
		else if (w >= TABLE_FIRST_WORD)
			return SECT_TABLE;
		else
			return SECT_APP;
	endfunction : sect_of

	// Lock pair of a section: bit LOCK_WR and bit LOCK_RW
	function automatic logic [1:0] locks_of(input logic [1:0] s, input logic [5:0] lv);
		case (s)
			SECT_TABLE: return lv[3:2];
			SECT_BOOT:  return lv[5:4];
			default:    return lv[1:0];
		endcase
	endfunction : locks_of

	logic [7:0]     rf [32];
	logic [15:0]    prog_addr_reg, prog_addr_next, exec_pc_reg, exec_pc_next;
	logic [15:0]    ir_reg, ir_next, fetch_save_reg, fetch_save_next;
	cmmd_state_type state_reg, state_next;
	logic [4:0]     load_rd_reg, load_rd_next;
	logic           lpm_hi_reg, lpm_hi_next, lpm_ok_reg, lpm_ok_next;
	logic [15:0]    data_addr_reg, data_addr_next;
	logic [7:0]     data_wdata_reg, data_wdata_next;
	logic           data_re_reg, data_re_next, data_we_reg, data_we_next;
	logic [2:0]     sel_reg, sel_next;
	logic           flash_wr_reg, flash_wr_next;
	logic [15:0]    flash_wr_addr_reg, flash_wr_addr_next;
	logic [7:0]     flash_wr_data_reg, flash_wr_data_next;
	logic [7:0]     status_reg, status_next;
	logic           fault_reg, fault_next;
	logic           rf_we;
	logic [4:0]     rf_waddr;
	logic [7:0]     rf_wdata;
	logic [5:0]     lock_vec;
	logic [3:0]     opcode;
	logic [4:0]     rd, rr;
	logic [7:0]     op_a, op_b;
	logic [15:0]    ptr_x, ptr_y, ptr_z, ptr_sel;

	// Field extraction and two-port register read
	assign opcode   = ir_reg[15:12];
	assign rd       = ir_reg[11:7];
	assign rr       = ir_reg[6:2];
	assign op_a     = rf[rd];
	assign op_b     = rf[rr];
	assign ptr_x    = {rf[PTR_X_LO + 5'h1], rf[PTR_X_LO]};
	assign ptr_y    = {rf[PTR_Y_LO + 5'h1], rf[PTR_Y_LO]};
	assign ptr_z    = {rf[PTR_Z_LO + 5'h1], rf[PTR_Z_LO]};
	assign ptr_sel  = (ir_reg[1:0] == 2'h0) ? ptr_x : (ir_reg[1:0] == 2'h1) ? ptr_y : ptr_z;
	assign lock_vec = {lock_boot_rw, lock_boot_wr, lock_tbl_rw, lock_tbl_wr,
		lock_app_rw, lock_app_wr};

	// Next-state computation for the sequencer, datapath and ports
	always_comb begin
		logic [8:0] sum;
		logic [7:0] res;
		logic [1:0] tl;
		sum = 9'h000;
		res = 8'h00;
		tl  = 2'h0;
		prog_addr_next     = prog_addr_reg;
		exec_pc_next       = exec_pc_reg;
		ir_next            = ir_reg;
		fetch_save_next    = fetch_save_reg;
		state_next         = state_reg;
		load_rd_next       = load_rd_reg;
		lpm_hi_next        = lpm_hi_reg;
		lpm_ok_next        = lpm_ok_reg;
		data_addr_next     = data_addr_reg;
		data_wdata_next    = data_wdata_reg;
		data_re_next       = 1'b0;
		data_we_next       = 1'b0;
		sel_next           = 3'h0;
		flash_wr_next      = 1'b0;
		flash_wr_addr_next = flash_wr_addr_reg;
		flash_wr_data_next = flash_wr_data_reg;
		status_next        = status_reg;
		fault_next         = 1'b0;
		rf_we              = 1'b0;
		rf_waddr           = rd;
		rf_wdata           = 8'h00;
		case (state_reg)
			ST_EXEC: begin
				// Overlapped fetch of the following word
				ir_next        = prog_rdata;
				exec_pc_next   = prog_addr_reg;
				prog_addr_next = prog_addr_reg + 16'h0001;
				case (opcode)
					OP_ADD, OP_SUB: begin
						sum = (opcode == OP_ADD) ? {1'b0, op_a} + {1'b0, op_b}
							: {1'b0, op_a} - {1'b0, op_b};
						res = sum[7:0];
						rf_we = 1'b1;
						rf_wdata = res;
						status_next[FLAG_C] = sum[8];
						status_next[FLAG_H] = (opcode == OP_ADD)
							? (op_a[3] & op_b[3]) | ((op_a[3] | op_b[3]) & ~res[3])
							: (~op_a[3] & op_b[3]) | ((~op_a[3] | op_b[3]) & res[3]);
						status_next[FLAG_V] = (opcode == OP_ADD)
							? (op_a[7] == op_b[7]) && (res[7] != op_a[7])
							: (op_a[7] != op_b[7]) && (res[7] != op_a[7]);
						status_next[FLAG_N] = res[7];
						status_next[FLAG_Z] = (res == 8'h00);
						status_next[FLAG_S] = res[7] ^ status_next[FLAG_V];
					end
					OP_AND, OP_OR: begin
						res = (opcode == OP_AND) ? (op_a & op_b) : (op_a | op_b);
						rf_we = 1'b1;
						rf_wdata = res;
						status_next[FLAG_V] = 1'b0;
						status_next[FLAG_N] = res[7];
						status_next[FLAG_Z] = (res == 8'h00);
						status_next[FLAG_S] = res[7];
					end
					OP_MOV: begin
						rf_we = 1'b1;
						rf_wdata = op_b;
					end
					OP_LDI: begin
						rf_we = 1'b1;
						rf_waddr = {1'b1, ir_reg[11:8]};
						rf_wdata = ir_reg[7:0];
					end
					OP_IN, OP_LD: begin
						// Direct I/O form only reaches 0x00..0x3F by its 6-bit field
						data_addr_next = (opcode == OP_IN) ? {10'h000, ir_reg[5:0]}
							: ptr_sel;
						sel_next     = dec_target(data_addr_next);
						data_re_next = |sel_next;
						fault_next   = ~|sel_next;
						load_rd_next = rd;
						state_next   = ST_LDWAIT;
					end
					OP_OUT, OP_ST: begin
						data_addr_next  = (opcode == OP_OUT) ? {10'h000, ir_reg[5:0]}
							: ptr_sel;
						data_wdata_next = op_a;
						sel_next        = dec_target(data_addr_next);
						data_we_next    = |sel_next;
						fault_next      = ~|sel_next;
					end
					OP_LPM: begin
						// Program space read through Z; a foreign read lock blocks it
						tl = locks_of(sect_of({1'b0, ptr_z[15:1]}), lock_vec);
						lpm_ok_next = ~tl[LOCK_RW] ||
							(sect_of({1'b0, ptr_z[15:1]}) == sect_of(exec_pc_reg));
						fault_next      = ~lpm_ok_next;
						lpm_hi_next     = ptr_z[0];
						load_rd_next    = rd;
						fetch_save_next = prog_addr_reg;
						prog_addr_next  = {1'b0, ptr_z[15:1]};
						ir_next         = ir_reg;
						exec_pc_next    = exec_pc_reg;
						state_next      = ST_LPMWAIT;
					end
					OP_SPM: begin
						tl = locks_of(sect_of({1'b0, ptr_z[15:1]}), lock_vec);
						if (sect_of(exec_pc_reg) == SECT_BOOT && tl == 2'h0) begin
							flash_wr_next      = 1'b1;
							flash_wr_addr_next = ptr_z;
							flash_wr_data_next = rf[5'h00];
						end else begin
							fault_next = 1'b1;
						end
					end
					default: ;
				endcase
			end
			ST_LDWAIT: begin
				// Target answers in the cycle its select is high
				rf_we      = 1'b1;
				rf_waddr   = load_rd_reg;
				rf_wdata   = data_rdata;
				state_next = ST_EXEC;
			end
			ST_LPMWAIT: begin
				rf_we          = 1'b1;
				rf_waddr       = load_rd_reg;
				rf_wdata       = !lpm_ok_reg ? 8'h00
					: lpm_hi_reg ? prog_rdata[15:8] : prog_rdata[7:0];
				prog_addr_next = fetch_save_reg;
				state_next     = ST_REFILL;
			end
			ST_REFILL: begin
				ir_next        = prog_rdata;
				exec_pc_next   = prog_addr_reg;
				prog_addr_next = prog_addr_reg + 16'h0001;
				state_next     = ST_EXEC;
			end
			default: state_next = ST_EXEC;
		endcase
	end

	// Register stage
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prog_addr_reg     <= PC_RESET;
			exec_pc_reg       <= PC_RESET;
			ir_reg            <= IR_RESET;
			fetch_save_reg    <= PC_RESET;
			state_reg         <= ST_EXEC;
			load_rd_reg       <= 5'h00;
			lpm_hi_reg        <= 1'b0;
			lpm_ok_reg        <= 1'b0;
			data_addr_reg     <= 16'h0000;
			data_wdata_reg    <= 8'h00;
			data_re_reg       <= 1'b0;
			data_we_reg       <= 1'b0;
			sel_reg           <= 3'h0;
			flash_wr_reg      <= 1'b0;
			flash_wr_addr_reg <= 16'h0000;
			flash_wr_data_reg <= 8'h00;
			status_reg        <= STATUS_RESET;
			fault_reg         <= 1'b0;
			for (int i = 0; i < 32; i++) begin
				rf[i] <= REG_RESET;
			end
		end else begin
			prog_addr_reg     <= prog_addr_next;
			exec_pc_reg       <= exec_pc_next;
			ir_reg            <= ir_next;
			fetch_save_reg    <= fetch_save_next;
			state_reg         <= state_next;
			load_rd_reg       <= load_rd_next;
			lpm_hi_reg        <= lpm_hi_next;
			lpm_ok_reg        <= lpm_ok_next;
			data_addr_reg     <= data_addr_next;
			data_wdata_reg    <= data_wdata_next;
			data_re_reg       <= data_re_next;
			data_we_reg       <= data_we_next;
			sel_reg           <= sel_next;
			flash_wr_reg      <= flash_wr_next;
			flash_wr_addr_reg <= flash_wr_addr_next;
			flash_wr_data_reg <= flash_wr_data_next;
			status_reg        <= status_next;
			fault_reg         <= fault_next;
			if (rf_we) begin
				rf[rf_waddr] <= rf_wdata;
			end
		end
	end

	// Outputs straight from flip-flops
	assign prog_addr     = prog_addr_reg;
	assign data_addr     = data_addr_reg;
	assign data_wdata    = data_wdata_reg;
	assign data_re       = data_re_reg;
	assign data_we       = data_we_reg;
	assign io_sel        = sel_reg[SEL_IO];
	assign eep_sel       = sel_reg[SEL_EEP];
	assign sram_sel      = sel_reg[SEL_SRAM];
	assign flash_wr      = flash_wr_reg;
	assign flash_wr_addr = flash_wr_addr_reg;
	assign flash_wr_data = flash_wr_data_reg;
	assign status_flags  = status_reg;
	assign access_fault  = fault_reg;

endmodule : cmmd_core

// *** pkg/cmmd_pkg.sv ***
// Constants, encodings and state type for the CPU memory map decoder
package cmmd_pkg;

	// Data space windows (byte addresses)
	localparam logic [15:0] IO_DIRECT_LAST   = 16'h003f;
	localparam logic [15:0] EXT_IO_FIRST     = 16'h0040;
	localparam logic [15:0] IO_LAST          = 16'h0fff;
	localparam logic [15:0] EEP_FIRST        = 16'h1000;
	localparam logic [15:0] EEP_LAST         = 16'h1fff;
	localparam logic [15:0] SRAM_FIRST       = 16'h2000;
	localparam logic [15:0] SRAM_LAST        = 16'h2fff;

	// Program space sections (word addresses)
	localparam logic [15:0] TABLE_FIRST_WORD = 16'h3000;
	localparam logic [15:0] BOOT_FIRST_WORD  = 16'h4000;

	// Values after reset
	localparam logic [15:0] PC_RESET         = 16'h0000;
	localparam logic [15:0] IR_RESET         = 16'h0000;
	localparam logic [7:0]  STATUS_RESET     = 8'h00;
	localparam logic [7:0]  REG_RESET        = 8'h00;

	// Status flag positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;

	// Target select positions
	localparam int SEL_IO   = 0;
	localparam int SEL_EEP  = 1;
	localparam int SEL_SRAM = 2;

	// Program sections and lock vector positions
	localparam logic [1:0] SECT_APP   = 2'h0;
	localparam logic [1:0] SECT_TABLE = 2'h1;
	localparam logic [1:0] SECT_BOOT  = 2'h2;
	localparam int LOCK_WR = 0;
	localparam int LOCK_RW = 1;

	// Pointer pair low register indices
	localparam logic [4:0] PTR_X_LO = 5'h1a;
	localparam logic [4:0] PTR_Y_LO = 5'h1c;
	localparam logic [4:0] PTR_Z_LO = 5'h1e;

	// Opcodes in instruction bits [15:12]
	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_ADD = 4'h1;
	localparam logic [3:0] OP_SUB = 4'h2;
	localparam logic [3:0] OP_AND = 4'h3;
	localparam logic [3:0] OP_OR  = 4'h4;
	localparam logic [3:0] OP_MOV = 4'h5;
	localparam logic [3:0] OP_LDI = 4'h6;
	localparam logic [3:0] OP_IN  = 4'h7;
	localparam logic [3:0] OP_OUT = 4'h8;
	localparam logic [3:0] OP_LD  = 4'h9;
	localparam logic [3:0] OP_ST  = 4'ha;
	localparam logic [3:0] OP_LPM = 4'hb;
	localparam logic [3:0] OP_SPM = 4'hc;

	// Sequencer states
	typedef enum logic [3:0] {
		ST_EXEC    = 4'b0001,
		ST_LDWAIT  = 4'b0010,
		ST_LPMWAIT = 4'b0100,
		ST_REFILL  = 4'b1000
	} cmmd_state_type;

endpackage : cmmd_pkg

// *** verif/cmmd_core_chk.sv ***
// Port checker for the memory map decoder core
`timescale 1ns/1ps
module cmmd_core_chk
	import cmmd_pkg::*;
(
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        reset,
	// Watched ports
	input wire logic [15:0] prog_addr,
	input wire logic [15:0] prog_rdata,
	input wire logic [15:0] data_addr,
	input wire logic        data_re,
	input wire logic        data_we,
	input wire logic        io_sel,
	input wire logic        eep_sel,
	input wire logic        sram_sel,
	input wire logic        flash_wr,
	input wire logic [15:0] flash_wr_addr,
	input wire logic        lock_app_wr,
	input wire logic        lock_app_rw,
	input wire logic        lock_tbl_wr,
	input wire logic        lock_tbl_rw,
	input wire logic        lock_boot_wr,
	input wire logic        lock_boot_rw
);
	logic lock_hit;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// Lock that guards the section a flash write aims at
	assign lock_hit = ({1'b0, flash_wr_addr[15:1]} >= BOOT_FIRST_WORD) ?
		(lock_boot_wr | lock_boot_rw) : ({1'b0, flash_wr_addr[15:1]} >= TABLE_FIRST_WORD) ?
		(lock_tbl_wr | lock_tbl_rw) : (lock_app_wr | lock_app_rw);

	AST_ONE_SEL: assert property ($onehot0({io_sel, eep_sel, sram_sel}))
		else $error("more than one target select");
	AST_SEL_STROBE: assert property ((io_sel | eep_sel | sram_sel) |-> (data_re ^ data_we))
		else $error("select without exactly one strobe");
	AST_IO_WIN: assert property (io_sel |-> data_addr <= IO_LAST)
		else $error("io select outside io window");
	AST_EEP_WIN: assert property (eep_sel |-> data_addr >= EEP_FIRST && data_addr <= EEP_LAST)
		else $error("eeprom select outside its window");
	AST_SRAM_WIN: assert property (sram_sel |-> data_addr >= SRAM_FIRST && data_addr <= SRAM_LAST)
		else $error("sram select outside its window");
	AST_NONE_OUTSIDE: assert property (data_addr > SRAM_LAST |-> !(io_sel | eep_sel | sram_sel))
		else $error("select for an unmapped address");
	AST_FETCH_START: assert property ($fell(reset) |-> prog_addr == 16'h0000 ##1 prog_addr == 16'h0001)
		else $error("first fetch after reset wrong");
	AST_FETCH_STEP: assert property (prog_rdata == 16'h0000 && $past(prog_rdata) == 16'h0000 && !$past(reset) |=> prog_addr == $past(prog_addr) + 16'h0001)
		else $error("fetch did not overlap execution");
	AST_FLASH_BOOT: assert property (flash_wr |-> $past(prog_addr) >= 16'h4001)
		else $error("flash write from outside boot part");
	AST_FLASH_LOCK: assert property (flash_wr |-> !lock_hit)
		else $error("flash write into a locked section");
endmodule : cmmd_core_chk

// *** verif/cmmd_core_tb.sv ***
// Self-checking testbench for the memory map decoder core
`timescale 1ns/1ps
module cmmd_core_tb
	import cmmd_pkg::*;
;
	// Application part program, from word zero
	localparam logic [15:0] APP_CODE [0:32] = '{16'h6005, 16'h6103, 16'h1844, 16'h6a00,
		16'h6b20, 16'h6c00, 16'h6d10, 16'h6e00, 16'h6f01, 16'ha800, 16'ha801, 16'ha802,
		16'h883f, 16'h793f, 16'h6c3f, 16'h6d00, 16'h9981, 16'ha900, 16'ha980, 16'h67ff,
		16'h6801, 16'h1be0, 16'hab80, 16'hba80, 16'haa80, 16'h6f60, 16'hbb00, 16'hab00,
		16'h6d30, 16'ha801, 16'hc000, 16'h28c4, 16'ha880};
	// Boot part program: self-programming stores
	localparam logic [15:0] BOOT_CODE [0:5] = '{16'hc000, 16'h6f01, 16'h5040, 16'hc000,
		16'h6f90, 16'hc000};
	// Expected stores: address, data, select {sram,eep,io}, flags
	localparam logic [39:0] EXP_LOG [0:9] = '{40'h2000080400, 40'h1000080200,
		40'h0100080100, 40'h003f080100, 40'h2000080400, 40'h2000080400, 40'h2000000423,
		40'h2000a50423, 40'h2000000423, 40'h2000000402};

	logic ref_clk, reset, data_re, data_we, io_sel, eep_sel, sram_sel, flash_wr, access_fault;
	logic lock_app_wr, lock_app_rw, lock_tbl_wr, lock_tbl_rw, lock_boot_wr, lock_boot_rw;
	logic [15:0] prog_addr, prog_rdata, data_addr, flash_wr_addr;
	logic [7:0]  data_wdata, data_rdata, flash_wr_data, status_flags;
	logic [39:0] wr_log [$];
	logic [23:0] fl_log [$];
	int          faults, miscompares, checks;

	cmmd_core uut (.ref_clk(ref_clk), .reset(reset), .prog_addr(prog_addr),
		.prog_rdata(prog_rdata), .data_addr(data_addr), .data_wdata(data_wdata),
		.data_rdata(data_rdata), .data_re(data_re), .data_we(data_we), .io_sel(io_sel),
		.eep_sel(eep_sel), .sram_sel(sram_sel), .flash_wr(flash_wr),
		.flash_wr_addr(flash_wr_addr), .flash_wr_data(flash_wr_data),
		.lock_app_wr(lock_app_wr), .lock_app_rw(lock_app_rw), .lock_tbl_wr(lock_tbl_wr),
		.lock_tbl_rw(lock_tbl_rw), .lock_boot_wr(lock_boot_wr), .lock_boot_rw(lock_boot_rw),
		.status_flags(status_flags), .access_fault(access_fault));

	cmmd_mem_model mem (.ref_clk(ref_clk), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
		.data_addr(data_addr), .data_wdata(data_wdata), .data_rdata(data_rdata),
		.data_re(data_re), .data_we(data_we), .sel({sram_sel, eep_sel, io_sel}),
		.flash_wr(flash_wr), .flash_wr_addr(flash_wr_addr), .flash_wr_data(flash_wr_data));

	// Clock of 5 ns
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Record stores, flash writes and faults seen at the ports
	always @(posedge ref_clk) begin
		if (!reset && data_we && (io_sel | eep_sel | sram_sel))
			wr_log.push_back({data_addr, data_wdata, 5'h00, sram_sel, eep_sel, io_sel, status_flags});
		if (!reset && flash_wr)
			fl_log.push_back({flash_wr_addr, flash_wr_data});
		if (!reset && access_fault)
			faults++;
	end

	// Compare one result
	task automatic check(input logic [39:0] got, input logic [39:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// Report and end the run
	task automatic complete_run();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run

	// Wait for the exact fetch address, bounded; table reads jump prog_addr far ahead
	task automatic wait_pc(input logic [15:0] target);
		for (int n = 0; n < 20000 && prog_addr !== target; n++) begin
			@(negedge ref_clk);
		end
	endtask : wait_pc

	// Load flash, hold reset seven cycles, check outputs at rest
	task automatic do_reset();
		@(negedge ref_clk);
		for (int i = 0; i < 33; i++) begin
			mem.prog_mem[i] = APP_CODE[i];
		end
		for (int i = 0; i < 6; i++) begin
			mem.prog_mem[16'h4000 + i] = BOOT_CODE[i];
		end
		mem.prog_mem[16'h0080] = 16'h12a5;
		mem.prog_mem[16'h3000] = 16'h34ff;
		repeat (6) @(negedge ref_clk);
		check({13'h0, prog_addr, data_we, data_re, flash_wr, status_flags}, 40'h0);
		reset = 1'b0;
	endtask : do_reset

	// Windows, direct and data-space I/O, flags, table read and its lock
	task automatic run_app_part();
		wait_pc(16'h0030);
		check(wr_log.size(), 40'd10);
		for (int i = 0; i < 10; i++) begin
			check(wr_log[i], EXP_LOG[i]);
		end
		check(status_flags, 40'h02);
		check(faults, 40'd3);
		lock_app_wr = 1'b0;
	endtask : run_app_part

	// Self-programming from the boot part against the section locks
	task automatic run_boot_part();
		wait_pc(16'h4010);
		check(fl_log.size(), 40'd1);
		check(fl_log[0], 40'h010008);
		check(faults, 40'd5);
		check(mem.prog_mem[16'h0080], 40'h1208);
	endtask : run_boot_part

	// Main sequence; table read-lock and boot write-lock stay set
	initial begin
		reset = 1'b1;
		lock_app_wr = 1'b1;
		lock_app_rw = 1'b0;
		lock_tbl_wr = 1'b0;
		lock_tbl_rw = 1'b1;
		lock_boot_wr = 1'b1;
		lock_boot_rw = 1'b0;
		do_reset();
		run_app_part();
		run_boot_part();
		complete_run();
	end

	// Watchdog well past the expected 16.4k cycles
	initial begin
		#200000;
		miscompares++;
		complete_run();
	end
endmodule : cmmd_core_tb

bind cmmd_core cmmd_core_chk chk (.ref_clk(ref_clk), .reset(reset), .prog_addr(prog_addr),
	.prog_rdata(prog_rdata), .data_addr(data_addr), .data_re(data_re), .data_we(data_we),
	.io_sel(io_sel), .eep_sel(eep_sel), .sram_sel(sram_sel), .flash_wr(flash_wr),
	.flash_wr_addr(flash_wr_addr), .lock_app_wr(lock_app_wr), .lock_app_rw(lock_app_rw),
	.lock_tbl_wr(lock_tbl_wr), .lock_tbl_rw(lock_tbl_rw), .lock_boot_wr(lock_boot_wr),
	.lock_boot_rw(lock_boot_rw));

// *** verif/cmmd_mem_model.sv ***
// Partner model: program flash and data-space targets of the core
`timescale 1ns/1ps
module cmmd_mem_model
	import cmmd_pkg::*;
(
	// Clock
	input  wire logic        ref_clk,
	// Program side
	input  wire logic [15:0] prog_addr,
	output logic [15:0]      prog_rdata,
	// Data side
	input  wire logic [15:0] data_addr,
	input  wire logic [7:0]  data_wdata,
	output logic [7:0]       data_rdata,
	input  wire logic        data_re,
	input  wire logic        data_we,
	input  wire logic [2:0]  sel,
	// Self-programming
	input  wire logic        flash_wr,
	input  wire logic [15:0] flash_wr_addr,
	input  wire logic [7:0]  flash_wr_data
);
	logic [15:0] prog_mem [0:65535];
	logic [7:0]  data_mem [0:12287];
	logic [7:0]  last_q = 8'h5a;

	// Flash answers in the same cycle, from storage apart from data space
	assign prog_rdata = prog_mem[prog_addr];
	// An unselected read shows a pattern that changes every cycle
	assign data_rdata = (data_re && |sel) ? data_mem[data_addr] : ~last_q;

	// Erased flash reads as NOP
	initial begin
		for (int i = 0; i < 65536; i++) begin
			prog_mem[i] = 16'h0000;
		end
	end

	// Stores and flash writes land at the clock edge
	always @(posedge ref_clk) begin
		last_q <= data_rdata;
		if (data_we && |sel)
			data_mem[data_addr] <= data_wdata;
		if (flash_wr)
			prog_mem[flash_wr_addr[15:1]][flash_wr_addr[0]*8 +: 8] <= flash_wr_data;
	end
endmodule : cmmd_mem_model
